// ==== hw/buf_fwd_defs.vh ====
// constants for the shared buffer control and frame forwarder
`ifndef BUF_FWD_DEFS_VH
`define BUF_FWD_DEFS_VH
`define NPORT 4
`define WORDS_FULL 15'h5d12
`define WORDS_SMALL 15'h2e89
`define WORD_BYTES 8'hb0
`define CLK_MHZ 10
`define REF_RATE_MIN_M 125
`define REF_RATE_MAX_M 250
`define REFS_PER_CYCLE 1
`define A_CTRL 12'h000
`define A_TTOT 12'h004
`define A_PTOT 12'h008
`define A_VSEL 12'h00c
`define A_VUSE 12'h010
`define A_FREE 12'h014
`define A_PCNT 12'h018
`define O_LIM 3'h0
`define O_PAUSE 3'h1
`define O_MODE 3'h2
`define O_STAT 3'h3
`define O_PRESS 3'h4
`define O_IDC 3'h5
`define O_EDC 3'h6
`define B_IDROP 4
`define B_EDROP 5
`define B_FCEN 6
`define PAUSE_STOP_LSB 16
`define R_LIM 15'h5d12
`define R_TOT 15'h0000
`define R_PST 15'h7fff
`define R_PSP 15'h0000
`define R_PTHR 8'hff
`define R_PLIM 4'hf
`endif

// ==== hw/buf_fwd.v ====
// shared buffer control, memory manager and frame forwarder
`timescale 1ns/1ps
`default_nettype none
`include "buf_fwd_defs.vh"
module buf_fwd (
    input wire pclk,
    input wire presetn,
    input wire [11:0] paddr,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [31:0] pwdata,
    output wire [31:0] prdata,
    output wire pready,
    output wire pslverr,
    input wire small_variant,
    input wire wr_req,
    input wire wr_sof,
    input wire [1:0] wr_port,
    output wire wr_ack,
    output wire wr_drop,
    output wire [14:0] wr_word,
    input wire rel_req,
    input wire [1:0] rel_port,
    input wire [14:0] rel_word,
    output wire [3:0] pause_req,
    input wire [3:0] iq_valid,
    input wire [59:0] iq_ref,
    input wire [15:0] iq_dest,
    input wire [3:0] iq_fdrop,
    input wire [31:0] iq_pend,
    output wire [3:0] iq_pop,
    input wire [3:0] eq_cong,
    output wire eq_valid,
    output wire [1:0] eq_port,
    output wire [14:0] eq_ref
);
localparam NP = `NPORT;
localparam IDLE = 1'b0;
localparam BUSY = 1'b1;

function [1:0] low_bit;
    input [3:0] m;
    integer k;
    begin
        low_bit = 2'h0;
        for (k = 3; k >= 0; k = k - 1)
            if (m[k])
                low_bit = k[1:0];
    end
endfunction

function [2:0] pop4;
    input [3:0] m;
    begin
        pop4 = {2'h0, m[0]} + {2'h0, m[1]} + {2'h0, m[2]} + {2'h0, m[3]};
    end
endfunction

function [14:0] wrap;
    input [14:0] p;
    input [14:0] lim;
    begin
        wrap = (p == lim - 15'h0001) ? 15'h0000 : p + 15'h0001;
    end
endfunction

integer i, j, q;

// strap is caught only after the synchroniser has settled
reg s1_ff, s2_ff, small_ff;
reg [1:0] scnt_ff;
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        s1_ff <= 1'b0;
        s2_ff <= 1'b0;
        small_ff <= 1'b0;
        scnt_ff <= 2'h0;
    end else begin
        s1_ff <= small_variant;
        s2_ff <= s1_ff;
        if (scnt_ff != 2'h3)
            scnt_ff <= scnt_ff + 2'h1;
        if (scnt_ff == 2'h2)
            small_ff <= s2_ff;
    end
end
wire mm_ready = scnt_ff == 2'h3;
wire [14:0] cap = small_ff ? `WORDS_SMALL : `WORDS_FULL;

// configuration
reg dsingle_ff;
reg [14:0] ttot_ff, ptot_ff;
reg [1:0] vsel_ff;
reg [14:0] lim_ff [0:NP-1];
reg [14:0] pst_ff [0:NP-1];
reg [14:0] psp_ff [0:NP-1];
reg [3:0] wgt_ff [0:NP-1];
reg [7:0] pthr_ff [0:NP-1];
reg [3:0] plim_ff [0:NP-1];
reg [3:0] idrop_ff, edrop_ff, fcen_ff, emode_ff;
reg [31:0] icnt_ff [0:NP-1];
reg [31:0] ecnt_ff [0:NP-1];
reg [31:0] pcnt_ff;

// memory manager: fresh words first, then recycled ones
reg [14:0] free_mem [0:`WORDS_FULL-15'h0001];
reg [14:0] fresh_ff, head_ff, tail_ff, flcnt_ff, used_ff;
reg [14:0] use_ff [0:NP-1];
reg [3:0] tdrop_ff, pause_ff;
reg ack_ff, drop_ff;
reg [14:0] word_ff;
wire from_fresh = fresh_ff != cap;
wire have_free = from_fresh | (flcnt_ff != 15'h0000);
wire [14:0] wuse = use_ff[wr_port];
wire over = (wuse >= lim_ff[wr_port]) && (used_ff >= ttot_ff);
wire drop_now = (wr_sof ? over : tdrop_ff[wr_port]) | ~have_free;
wire take = wr_req & mm_ready & ~drop_now;
wire pop_fl = take & ~from_fresh;
wire [14:0] give = from_fresh ? fresh_ff : free_mem[head_ff];

always @(posedge pclk) begin
    if (rel_req)
        free_mem[tail_ff] <= rel_word;
end

always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        fresh_ff <= 15'h0000;
        head_ff <= 15'h0000;
        tail_ff <= 15'h0000;
        flcnt_ff <= 15'h0000;
        used_ff <= 15'h0000;
        tdrop_ff <= 4'h0;
        pause_ff <= 4'h0;
        ack_ff <= 1'b0;
        drop_ff <= 1'b0;
        word_ff <= 15'h0000;
        for (i = 0; i < NP; i = i + 1)
            use_ff[i] <= 15'h0000;
    end else begin
        ack_ff <= take;
        drop_ff <= wr_req & ~take;
        if (take)
            word_ff <= give;
        if (take && from_fresh)
            fresh_ff <= fresh_ff + 15'h0001;
        if (pop_fl)
            head_ff <= wrap(head_ff, cap);
        if (rel_req)
            tail_ff <= wrap(tail_ff, cap);
        flcnt_ff <= flcnt_ff + {14'h0, rel_req} - {14'h0, pop_fl};
        used_ff <= used_ff + {14'h0, take} - {14'h0, rel_req};
        // a first word dropped by the port limit or an empty pool drops the whole frame; later words of an accepted frame still drop when no word is free
        if (wr_req && wr_sof)
            tdrop_ff[wr_port] <= drop_now;
        for (i = 0; i < NP; i = i + 1) begin
            use_ff[i] <= use_ff[i] + {14'h0, take && wr_port == i[1:0]}
                - {14'h0, rel_req && rel_port == i[1:0]};
            // start above stop gives hysteresis instead of chatter
            if (fcen_ff[i] && use_ff[i] >= pst_ff[i] && used_ff >= ptot_ff)
                pause_ff[i] <= 1'b1;
            else if (!fcen_ff[i] || use_ff[i] < psp_ff[i])
                pause_ff[i] <= 1'b0;
        end
    end
end
assign wr_ack = ack_ff;
assign wr_drop = drop_ff;
assign wr_word = word_ff;
assign pause_req = pause_ff;

// forwarder
reg st_ff, fany_ff, many_ff;
reg [1:0] cur_ff;
reg [3:0] rem_ff, credit_ff, copies_ff;
reg eqv_ff;
reg [1:0] eqp_ff;
reg [14:0] eqr_ff;
wire [14:0] cref = iq_ref[cur_ff*15 +: 15];
wire [7:0] cpend = iq_pend[cur_ff*8 +: 8];
wire press = (cpend > pthr_ff[cur_ff]) && (copies_ff >= plim_ff[cur_ff]);
wire idm = idrop_ff[cur_ff] | iq_fdrop[cur_ff];
wire [3:0] dmask = rem_ff & (press ? 4'hf : (eq_cong & (edrop_ff | {4{idm}})));
wire single = dsingle_ff | emode_ff[cur_ff];
wire [1:0] dlow = low_bit(rem_ff);
wire [3:0] dbit = 4'h1 << dlow;
wire [3:0] keep = rem_ff & ~dmask;
wire [1:0] flow = low_bit(keep);
wire [3:0] fbit = 4'h1 << flow;

reg [3:0] nxt_rem, ddisc;
reg emit;
reg [1:0] eport;
always @* begin
    nxt_rem = rem_ff;
    ddisc = 4'h0;
    emit = 1'b0;
    eport = dlow;
    if (st_ff == BUSY && rem_ff != 4'h0) begin
        if (single) begin
            if (dmask[dlow])
                ddisc = dbit;
            else if (!eq_cong[dlow])
                emit = 1'b1;
            // a congested flow control copy stays and blocks the port
            if (dmask[dlow] || !eq_cong[dlow])
                nxt_rem = rem_ff & ~dbit;
        end else begin
            ddisc = dmask;
            eport = flow;
            if (keep != 4'h0 && !eq_cong[flow])
                emit = 1'b1;
            nxt_rem = keep & ~(emit ? fbit : 4'h0);
        end
    end
end
wire done = (st_ff == BUSY) && (nxt_rem == 4'h0);
assign iq_pop = done ? (4'h1 << cur_ff) : 4'h0;

reg [1:0] rr_next;
reg [2:0] k;
always @* begin
    rr_next = cur_ff;
    for (k = 3'h4; k >= 3'h1; k = k - 3'h1)
        if (iq_valid[cur_ff + k[1:0]])
            rr_next = cur_ff + k[1:0];
end
wire stay = iq_valid[cur_ff] && credit_ff != 4'h0;
wire [1:0] pick = stay ? cur_ff : rr_next;

always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        st_ff <= IDLE;
        cur_ff <= 2'h0;
        rem_ff <= 4'h0;
        credit_ff <= 4'h0;
        copies_ff <= 4'h0;
        fany_ff <= 1'b0;
        many_ff <= 1'b0;
        eqv_ff <= 1'b0;
        eqp_ff <= 2'h0;
        eqr_ff <= 15'h0000;
        pcnt_ff <= 32'h0;
        for (j = 0; j < NP; j = j + 1) begin
            icnt_ff[j] <= 32'h0;
            ecnt_ff[j] <= 32'h0;
        end
    end else begin
        eqv_ff <= emit;
        if (emit) begin
            eqp_ff <= eport;
            eqr_ff <= cref;
        end
        case (st_ff)
            IDLE: begin
                if (iq_valid != 4'h0) begin
                    // weight plus one frames in a row before moving on
                    cur_ff <= pick;
                    credit_ff <= stay ? credit_ff - 4'h1 : wgt_ff[pick];
                    rem_ff <= iq_dest[pick*4 +: 4];
                    copies_ff <= 4'h0;
                    fany_ff <= 1'b0;
                    many_ff <= 1'b0;
                    st_ff <= BUSY;
                end
            end
            BUSY: begin
                rem_ff <= nxt_rem;
                copies_ff <= copies_ff + {3'h0, emit};
                fany_ff <= fany_ff | emit;
                many_ff <= many_ff | (ddisc != 4'h0);
                if (press)
                    pcnt_ff <= pcnt_ff + {29'h0, pop4(ddisc)};
                for (j = 0; j < NP; j = j + 1)
                    if (emode_ff[cur_ff] && ddisc[j])
                        ecnt_ff[j] <= ecnt_ff[j] + 32'h1;
                if (!emode_ff[cur_ff] && dsingle_ff)
                    icnt_ff[cur_ff] <= icnt_ff[cur_ff] + {29'h0, pop4(ddisc)};
                if (!single && done && !fany_ff && !emit && (many_ff || ddisc != 4'h0))
                    icnt_ff[cur_ff] <= icnt_ff[cur_ff] + 32'h1;
                if (done)
                    st_ff <= IDLE;
            end
            default: st_ff <= IDLE;
        endcase
    end
end
assign eq_valid = eqv_ff;
assign eq_port = eqp_ff;
assign eq_ref = eqr_ff;

// apb slave, no wait states, read data captured in the setup cycle
wire pblk = paddr[11:7] == 5'h02;
wire [1:0] pp = paddr[6:5];
wire [2:0] pw = paddr[4:2];
wire wen = psel & penable & pwrite;
reg [31:0] rd;
reg hit;
reg [31:0] prdata_ff;
reg perr_ff;
always @* begin
    rd = 32'h0;
    hit = 1'b1;
    if (pblk) begin
        case (pw)
            `O_LIM: rd = {17'h0, lim_ff[pp]};
            `O_PAUSE: rd = {1'b0, psp_ff[pp], 1'b0, pst_ff[pp]};
            `O_MODE: rd = {25'h0, fcen_ff[pp], edrop_ff[pp], idrop_ff[pp], wgt_ff[pp]};
            `O_STAT: rd = {31'h0, emode_ff[pp]};
            `O_PRESS: rd = {20'h0, plim_ff[pp], pthr_ff[pp]};
            `O_IDC: rd = icnt_ff[pp];
            `O_EDC: rd = ecnt_ff[pp];
            default: hit = 1'b0;
        endcase
    end else begin
        case (paddr)
            `A_CTRL: rd = {31'h0, dsingle_ff};
            `A_TTOT: rd = {17'h0, ttot_ff};
            `A_PTOT: rd = {17'h0, ptot_ff};
            `A_VSEL: rd = {30'h0, vsel_ff};
            `A_VUSE: rd = {17'h0, use_ff[vsel_ff]};
            `A_FREE: rd = {17'h0, cap - used_ff};
            `A_PCNT: rd = pcnt_ff;
            default: hit = 1'b0;
        endcase
    end
end

always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        prdata_ff <= 32'h0;
        perr_ff <= 1'b0;
        dsingle_ff <= 1'b0;
        ttot_ff <= `R_TOT;
        ptot_ff <= `R_TOT;
        vsel_ff <= 2'h0;
        idrop_ff <= 4'h0;
        edrop_ff <= 4'h0;
        fcen_ff <= 4'h0;
        emode_ff <= 4'h0;
        for (q = 0; q < NP; q = q + 1) begin
            lim_ff[q] <= `R_LIM;
            pst_ff[q] <= `R_PST;
            psp_ff[q] <= `R_PSP;
            wgt_ff[q] <= 4'h0;
            pthr_ff[q] <= `R_PTHR;
            plim_ff[q] <= `R_PLIM;
        end
    end else begin
        if (psel && !penable) begin
            prdata_ff <= pwrite ? 32'h0 : rd;
            perr_ff <= ~hit;
        end
        if (wen && hit && pblk) begin
            case (pw)
                `O_LIM: lim_ff[pp] <= pwdata[14:0];
                `O_PAUSE: begin
                    pst_ff[pp] <= pwdata[14:0];
                    psp_ff[pp] <= pwdata[`PAUSE_STOP_LSB +: 15];
                end
                `O_MODE: begin
                    wgt_ff[pp] <= pwdata[3:0];
                    idrop_ff[pp] <= pwdata[`B_IDROP];
                    edrop_ff[pp] <= pwdata[`B_EDROP];
                    fcen_ff[pp] <= pwdata[`B_FCEN];
                end
                `O_STAT: emode_ff[pp] <= pwdata[0];
                `O_PRESS: begin
                    pthr_ff[pp] <= pwdata[7:0];
                    plim_ff[pp] <= pwdata[11:8];
                end
                default: ;
            endcase
        end
        if (wen && hit && !pblk) begin
            case (paddr)
                `A_CTRL: dsingle_ff <= pwdata[0];
                `A_TTOT: ttot_ff <= pwdata[14:0];
                `A_PTOT: ptot_ff <= pwdata[14:0];
                `A_VSEL: vsel_ff <= pwdata[1:0];
                default: ;
            endcase
        end
    end
end
assign prdata = prdata_ff;
assign pready = 1'b1;
assign pslverr = perr_ff & psel & penable;

endmodule // buf_fwd
`default_nettype wire

// ==== verif/fwd_partner.sv ====
// ingress queue heads and egress reference log beside the forwarder
`timescale 1ns/1ps
`default_nettype none
module fwd_partner (
    input wire logic pclk,
    input wire logic [3:0] iq_pop,
    input wire logic eq_valid,
    input wire logic [1:0] eq_port,
    input wire logic [14:0] eq_ref,
    output logic [3:0] iq_valid,
    output logic [59:0] iq_ref,
    output logic [15:0] iq_dest,
    output logic [3:0] iq_fdrop,
    output logic [31:0] iq_pend
);
    logic [3:0] seen;
    logic [14:0] last_ref;
    initial {iq_valid, iq_ref, iq_dest, iq_fdrop, iq_pend, seen, last_ref} = '0;
    task automatic put(input int p, input logic [14:0] rf, input logic [3:0] d,
        input logic f, input logic [7:0] n);
        iq_ref[15*p +: 15] <= rf;
        iq_dest[4*p +: 4] <= d;
        iq_fdrop[p] <= f;
        iq_pend[8*p +: 8] <= n;
        iq_valid[p] <= 1'b1;
        seen <= 4'h0;
    endtask
    // a consumed head shows inverted reference and destination fields, so stale data cannot pass
    always @(posedge pclk) begin
        for (int i = 0; i < 4; i++) begin
            if (iq_pop[i] === 1'b1) begin
                iq_valid[i] <= 1'b0;
                iq_ref[15*i +: 15] <= ~iq_ref[15*i +: 15];
                iq_dest[4*i +: 4] <= ~iq_dest[4*i +: 4];
            end
        end
        if (eq_valid === 1'b1) begin
            seen[eq_port] <= 1'b1;
            last_ref <= eq_ref;
        end
    end
endmodule // fwd_partner
`default_nettype wire

// ==== verif/buf_fwd_properties.sv ====
// port assertions for the buffer control and forwarder
`timescale 1ns/1ps
`default_nettype none
module buf_fwd_checker (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire pslverr,
    input wire wr_req,
    input wire wr_ack,
    input wire wr_drop,
    input wire [14:0] wr_word,
    input wire [3:0] pause_req,
    input wire [3:0] iq_valid,
    input wire [3:0] iq_pop,
    input wire eq_valid
);
    logic any_v;
    logic apb_w;
    assign any_v = |iq_valid;
    assign apb_w = psel & penable & pwrite;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_err_phase: assert property (pslverr |-> psel && penable)
        else $error("error outside access");
    a_alloc_answer: assert property (wr_req |=> wr_ack != wr_drop)
        else $error("no single answer");
    a_alloc_quiet: assert property (!wr_req |=> !(wr_ack || wr_drop))
        else $error("answer without request");
    a_word_hold: assert property (!wr_ack |-> wr_word == $past(wr_word))
        else $error("word moved without grant");
    a_pop_valid: assert property ((iq_pop & ~iq_valid) == 4'h0)
        else $error("pop of empty queue");
    a_pop_single: assert property ($onehot0(iq_pop))
        else $error("two queues popped");
    a_ref_source: assert property (eq_valid |-> $past(any_v))
        else $error("reference without head");
    // pause only follows a counter change or a setting change
    a_pause_cause: assert property ((pause_req & ~$past(pause_req)) != 4'h0 |->
        $past(wr_req) || $past(wr_req, 2) || $past(wr_req, 3) || $past(apb_w)
        || $past(apb_w, 2) || $past(apb_w, 3))
        else $error("pause without cause");
endmodule // buf_fwd_checker
`default_nettype wire

// ==== verif/buf_fwd_bench.sv ====
// self-checking bench for the shared buffer and frame forwarder
`timescale 1ns/1ps
`default_nettype none
module buf_fwd_bench;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, small_variant;
    logic wr_req, wr_sof, wr_ack, wr_drop, rel_req, eq_valid, ack, drp;
    logic [1:0] wr_port, rel_port, eq_port;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, iq_pend, r;
    logic [14:0] wr_word, rel_word, eq_ref, wd, w0, w1;
    logic [3:0] pause_req, iq_valid, iq_fdrop, iq_pop, eq_cong;
    logic [59:0] iq_ref;
    logic [15:0] iq_dest;
    int n_errors, compares;
    buf_fwd dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .small_variant(small_variant),
        .wr_req(wr_req), .wr_sof(wr_sof), .wr_port(wr_port), .wr_ack(wr_ack),
        .wr_drop(wr_drop), .wr_word(wr_word), .rel_req(rel_req), .rel_port(rel_port),
        .rel_word(rel_word), .pause_req(pause_req), .iq_valid(iq_valid),
        .iq_ref(iq_ref), .iq_dest(iq_dest), .iq_fdrop(iq_fdrop), .iq_pend(iq_pend),
        .iq_pop(iq_pop), .eq_cong(eq_cong), .eq_valid(eq_valid), .eq_port(eq_port),
        .eq_ref(eq_ref));
    fwd_partner pm (.pclk(pclk), .iq_pop(iq_pop), .eq_valid(eq_valid),
        .eq_port(eq_port), .eq_ref(eq_ref), .iq_valid(iq_valid), .iq_ref(iq_ref),
        .iq_dest(iq_dest), .iq_fdrop(iq_fdrop), .iq_pend(iq_pend));
    always #50 pclk = ~pclk;
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic finish_test;
        $display("errors %0d compares %0d", n_errors, compares);
        if (n_errors == 0 && compares > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic hang;
        n_errors++;
        $display("[FAIL] %0t: wait limit used up", $time);
        finish_test();
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
        output logic e);
        int k;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
            if (k > 20) hang();
        end while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic e;
        apb(1'b1, a, d, e);
    endtask
    task automatic rdx(input logic [11:0] a, input logic [31:0] x);
        logic e;
        apb(1'b0, a, 32'h0, e);
        check(r, x);
    endtask
    task automatic alloc(input logic [1:0] p, input logic s);
        wr_req <= 1'b1;
        wr_sof <= s;
        wr_port <= p;
        @(posedge pclk);
        wr_req <= 1'b0;
        @(posedge pclk);
        ack = wr_ack;
        drp = wr_drop;
        wd = wr_word;
    endtask
    task automatic rel(input logic [1:0] p, input logic [14:0] w);
        rel_req <= 1'b1;
        rel_port <= p;
        rel_word <= w;
        @(posedge pclk);
        rel_req <= 1'b0;
        @(posedge pclk);
    endtask
    // with stall set the head must wait until congestion is lifted
    task automatic frm(input int p, input logic [14:0] rf, input logic [3:0] d,
        input logic f, input logic [7:0] n, input logic stall);
        int k;
        pm.put(p, rf, d, f, n);
        if (stall) begin
            repeat (20) @(posedge pclk);
            check({27'h0, iq_valid[p], pm.seen}, 32'h10);
            eq_cong <= 4'h0;
        end
        k = 0;
        do begin
            @(posedge pclk);
            k++;
            if (k > 60) hang();
        end while (iq_pop[p] !== 1'b1);
        repeat (3) @(posedge pclk);
    endtask
    task automatic t_regs;
        logic e;
        rdx(12'h100, 32'h00005d12);
        rdx(12'h104, 32'h00007fff);
        rdx(12'h004, 32'h00000000);
        rdx(12'h014, 32'h00005d12);
        wr(12'h014, 32'h00000000);
        rdx(12'h014, 32'h00005d12);
        apb(1'b0, 12'hffc, 32'h0, e);
        check({31'h0, e}, 32'h00000001);
    endtask
    task automatic t_alloc;
        alloc(2'h1, 1'b1);
        check({16'h0, ack, wd}, 32'h00008000);
        wr(12'h00c, 32'h00000001);
        rdx(12'h010, 32'h00000001);
        rdx(12'h014, 32'h00005d11);
        rel(2'h1, wd);
        rdx(12'h010, 32'h00000000);
    endtask
    task automatic t_tail;
        wr(12'h120, 32'h00000001);
        wr(12'h004, 32'h00000001);
        alloc(2'h1, 1'b1);
        w0 = wd;
        check({30'h0, ack, drp}, 32'h2);
        alloc(2'h1, 1'b1);
        check({30'h0, ack, drp}, 32'h1);
        alloc(2'h1, 1'b0);
        check({30'h0, ack, drp}, 32'h1);
        wr(12'h004, 32'h00000002);
        alloc(2'h1, 1'b1);
        w1 = wd;
        check({30'h0, ack, drp}, 32'h2);
        rel(2'h1, w0);
        rel(2'h1, w1);
    endtask
    task automatic t_pause;
        wr(12'h008, 32'h00007fff);
        wr(12'h144, 32'h00010002);
        wr(12'h148, 32'h00000040);
        alloc(2'h2, 1'b1);
        w0 = wd;
        alloc(2'h2, 1'b0);
        w1 = wd;
        repeat (2) @(posedge pclk);
        check({28'h0, pause_req}, 32'h0);
        wr(12'h008, 32'h00000000);
        repeat (2) @(posedge pclk);
        check({28'h0, pause_req}, 32'h4);
        rel(2'h2, w0);
        repeat (2) @(posedge pclk);
        check({28'h0, pause_req}, 32'h4);
        rel(2'h2, w1);
        repeat (2) @(posedge pclk);
        check({28'h0, pause_req}, 32'h0);
    endtask
    task automatic t_fwd;
        frm(0, 15'h0005, 4'h6, 1'b0, 8'h00, 1'b0);
        check({13'h0, pm.last_ref, pm.seen}, {13'h0, 15'h0005, 4'h6});
        wr(12'h108, 32'h00000010);
        eq_cong <= 4'h2;
        frm(0, 15'h0006, 4'h6, 1'b0, 8'h00, 1'b0);
        check({28'h0, pm.seen}, 32'h4);
        frm(0, 15'h0007, 4'h2, 1'b0, 8'h00, 1'b0);
        rdx(12'h114, 32'h00000001);
        wr(12'h000, 32'h00000001);
        eq_cong <= 4'h6;
        frm(0, 15'h0008, 4'h6, 1'b0, 8'h00, 1'b0);
        rdx(12'h114, 32'h00000003);
        wr(12'h000, 32'h00000000);
        wr(12'h10c, 32'h00000001);
        eq_cong <= 4'h2;
        frm(0, 15'h0009, 4'h2, 1'b0, 8'h00, 1'b0);
        rdx(12'h138, 32'h00000001);
        frm(3, 15'h000a, 4'h2, 1'b0, 8'h00, 1'b1);
        check({28'h0, pm.seen}, 32'h2);
        eq_cong <= 4'h2;
        frm(3, 15'h000b, 4'h2, 1'b1, 8'h00, 1'b0);
        check({28'h0, pm.seen}, 32'h0);
        wr(12'h148, 32'h00000060);
        eq_cong <= 4'h4;
        frm(3, 15'h000c, 4'h4, 1'b0, 8'h00, 1'b0);
        check({28'h0, pm.seen}, 32'h0);
        eq_cong <= 4'h0;
        wr(12'h110, 32'h00000100);
        frm(0, 15'h000d, 4'h7, 1'b0, 8'h05, 1'b0);
        check({28'h0, pm.seen}, 32'h1);
        rdx(12'h018, 32'h00000002);
    endtask
    // ports 0 and 2 wait together after port 1: the search starts past port 1
    task automatic t_rr;
        frm(1, 15'h000e, 4'h0, 1'b0, 8'h00, 1'b0);
        pm.put(0, 15'h000f, 4'h0, 1'b0, 8'h00);
        pm.put(2, 15'h0010, 4'h0, 1'b0, 8'h00);
        repeat (3) @(posedge pclk);
        check({28'h0, iq_valid}, 32'h1);
        repeat (3) @(posedge pclk);
        check({28'h0, iq_valid}, 32'h0);
    endtask
    // mid-run reset with the strap high brings up the smaller memory
    task automatic t_small;
        small_variant <= 1'b1;
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        alloc(2'h0, 1'b1);
        check({30'h0, ack, drp}, 32'h1);
        repeat (2) @(posedge pclk);
        rdx(12'h014, 32'h00002e89);
        rdx(12'h004, 32'h00000000);
    endtask
    initial begin
        pclk = 1'b0;
        presetn = 1'b0;
        {psel, penable, pwrite, small_variant, wr_req, wr_sof, rel_req} = '0;
        {paddr, pwdata, wr_port, rel_port, rel_word, eq_cong} = '0;
        n_errors = 0;
        compares = 0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        repeat (4) @(posedge pclk);
        t_regs();
        t_alloc();
        t_tail();
        t_pause();
        t_fwd();
        t_rr();
        t_small();
        finish_test();
    end
endmodule // buf_fwd_bench
bind buf_fwd buf_fwd_checker chk (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pslverr(pslverr), .wr_req(wr_req),
    .wr_ack(wr_ack), .wr_drop(wr_drop), .wr_word(wr_word), .pause_req(pause_req),
    .iq_valid(iq_valid), .iq_pop(iq_pop), .eq_valid(eq_valid));
`default_nettype wire
